/* hdl/ssq_pkg.sv */
// Shared constants for the step/direction microstep sequencer
package ssq_pkg;
  // Clock figures
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // Table geometry: one electrical period, four full steps
  localparam int TBL_ENTRIES = 1024;
  localparam int POS_W = 10;
  localparam int HALF_ENTRIES = 512;
  localparam int MAG_W = 8;
  localparam int CUR_W = 9;
  localparam logic [9:0] QUARTER_OFS = 10'h100;
  localparam logic [9:0] POS_RST = 10'h000;
  // Resolution codes: width is 1 << code
  localparam int RES_W = 4;
  localparam logic [3:0] RES_FINEST = 4'h0;
  localparam logic [3:0] RES_QUARTER = 4'h6;
  localparam logic [3:0] RES_HALF = 4'h7;
  localparam logic [3:0] RES_FULL = 4'h8;
  localparam logic [9:0] HALF_FIRST = 10'h040;
  localparam logic [9:0] QUARTER_FIRST = 10'h020;
  localparam logic [7:0] FULL_LOW = 8'h80;
  // Step period limit before standstill, in system clocks
  localparam int PER_W = 21;
  localparam int STST_PERIOD_CLKS = 2 ** 20;
  localparam logic [20:0] PER_ONE = 21'h000001;
  localparam logic [20:0] PER_ZERO = 21'h000000;
  localparam logic [8:0] REM_ZERO = 9'h000;
endpackage : ssq_pkg

/* hdl/ssq_sine_rom.sv */
// Sine magnitude table with registered sine and cosine outputs
`timescale 1ns/1ns
`default_nettype none
module ssq_sine_rom
  import ssq_pkg::*;
(
  input wire logic mclk,
  input wire logic [ssq_pkg::POS_W-1:0] idx_a,
  input wire logic [ssq_pkg::POS_W-1:0] idx_b,
  output logic signed [ssq_pkg::CUR_W-1:0] cur_a,
  output logic signed [ssq_pkg::CUR_W-1:0] cur_b
);
  logic [MAG_W-1:0] mag [HALF_ENTRIES];
  logic [MAG_W-1:0] mag_a;
  logic [MAG_W-1:0] mag_b;

  // Half wave from a rational approximation; sign comes from the top bit
  for (genvar i = 0; i < HALF_ENTRIES; i++) begin : g_mag
    localparam int PR = i * (HALF_ENTRIES - i);
    localparam int DEN = (5 * HALF_ENTRIES * HALF_ENTRIES) / 4 - PR;
    assign mag[i] = MAG_W'((255 * 4 * PR) / DEN);
  end

  assign mag_a = mag[idx_a[POS_W-2:0]];
  assign mag_b = mag[idx_b[POS_W-2:0]];

  // One register stage so the caller sees clean flop outputs
  always_ff @(posedge mclk) begin
    cur_a <= idx_a[POS_W-1] ? -$signed({1'b0, mag_a}) : $signed({1'b0, mag_a});
    cur_b <= idx_b[POS_W-1] ? -$signed({1'b0, mag_b}) : $signed({1'b0, mag_b});
  end
endmodule : ssq_sine_rom
`default_nettype wire

/* hdl/ssq_sequencer.sv */
// Step/direction microstep sequencer with interpolation and standstill
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Rising step edges and resolution changes move the counter
// - Step and direction synchronised before use
// - 1024 entry sine table indexed by counter
// - Direction low adds width, high subtracts
// - Width doubles per coarser resolution, max 256
// - Coarser resolution snaps to nearest valid
// - Full step positions 128, 384, 640, 896
// - Half step starts 64, spacing 128
// - Quarter step starts 32, spacing 64
// - Interpolate microsteps of one table entry
// - Split previous period into equal parts
// - Interpolation period limited to 2^20 clocks
// - Slow step rate declares standstill
// - Standstill starts reduction if pin allows
// - Next step edge clears standstill
// - New step drops unissued microsteps
// - Ten bit counter wraps both ways
module ssq_sequencer
  import ssq_pkg::*;
#(
  parameter int STST_CYCLES = ssq_pkg::STST_PERIOD_CLKS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic [ssq_pkg::RES_W-1:0] res_sel,
  input wire logic power_down_select_pin,
  output logic [ssq_pkg::POS_W-1:0] microstep_position_count,
  output logic signed [ssq_pkg::CUR_W-1:0] coil_a_cur,
  output logic signed [ssq_pkg::CUR_W-1:0] coil_b_cur,
  output logic standstill,
  output logic standby_reduce
);
  localparam logic [PER_W-1:0] PER_MAX = PER_W'(STST_CYCLES);
  // Largest microstep backlog, one full step of single entries
  localparam logic [8:0] REM_MAX = 9'h100;

  // Synchroniser stages; first stage feeds only the second
  logic step_s1_r, step_s2_r, step_s3_r;
  logic dir_s1_r, dir_s2_r;
  logic pdn_s1_r, pdn_s2_r;
  logic [RES_W-1:0] res_s1_r, res_s2_r;
  // Extra stage and held code: a multi-bit pin word may arrive skewed
  logic [RES_W-1:0] res_s3_r, res_hold_r;

  logic [RES_W-1:0] res_r;
  logic [POS_W-1:0] tgt_r, tgt_nxt;
  logic [POS_W-1:0] pos_r, pos_nxt;
  logic [PER_W-1:0] per_cnt_r, per_cnt_nxt;
  logic [PER_W-1:0] period_r, period_nxt;
  logic [PER_W-1:0] ival_cnt_r, ival_cnt_nxt;
  logic [8:0] rem_r, rem_nxt;
  logic dir_run_r, dir_run_nxt;
  logic stst_r, stst_nxt;
  logic standby_r;
  logic signed [CUR_W-1:0] rom_a, rom_b;

  // Input synchronisers, two flops before any logic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      step_s1_r <= 1'b0;
      step_s2_r <= 1'b0;
      step_s3_r <= 1'b0;
      dir_s1_r <= 1'b0;
      dir_s2_r <= 1'b0;
      pdn_s1_r <= 1'b0;
      pdn_s2_r <= 1'b0;
      res_s1_r <= RES_FINEST;
      res_s2_r <= RES_FINEST;
      res_s3_r <= RES_FINEST;
      res_hold_r <= RES_FINEST;
    end else begin
      step_s1_r <= step_in;
      step_s2_r <= step_s1_r;
      step_s3_r <= step_s2_r;
      dir_s1_r <= dir_in;
      dir_s2_r <= dir_s1_r;
      pdn_s1_r <= power_down_select_pin;
      pdn_s2_r <= pdn_s1_r;
      res_s1_r <= res_sel;
      res_s2_r <= res_s1_r;
      res_s3_r <= res_s2_r;
      // Take the code only once two samples agree, so no torn word
      if (res_s2_r == res_s3_r) begin
        res_hold_r <= res_s2_r;
      end
    end
  end

  // Edge detect on the synchronised step only
  wire step_rise = step_s2_r & ~step_s3_r;
  // Codes beyond full step clamp to full step
  wire [RES_W-1:0] res_new = (res_hold_r > RES_FULL) ? RES_FULL : res_hold_r;
  wire res_up = res_new > res_r;
  wire res_chg = res_new != res_r;

  // Step width and the half-width offset of valid positions
  wire [POS_W-1:0] width_new = POS_W'(11'h001 << res_new);
  wire [POS_W-1:0] half_new = width_new >> 1;
  wire [POS_W-1:0] mask_new = ~(width_new - 10'h001);
  // Blocks of one width are centred on valid positions, so masking
  // the low bits and adding the offset gives the nearest one
  wire [POS_W-1:0] snap_pos = (tgt_r & mask_new) + half_new;
  wire [POS_W-1:0] tgt_base = res_up ? snap_pos : tgt_r;
  // Counter wraps naturally in ten bits
  wire [POS_W-1:0] tgt_step = dir_s2_r ? tgt_base - width_new
                                       : tgt_base + width_new;

  // Microstep interval: measured period split into width parts
  wire [PER_W-1:0] ival_len = period_r >> res_r;
  wire [PER_W-1:0] ival_last = (ival_len == PER_ZERO) ? PER_ZERO
                                                     : ival_len - PER_ONE;
  wire ival_tick = (rem_r != REM_ZERO) && (ival_cnt_r >= ival_last);
  wire per_full = per_cnt_r >= PER_MAX;

  // Target, interpolation and period measurement
  always_comb begin
    tgt_nxt = tgt_base;
    pos_nxt = pos_r;
    rem_nxt = rem_r;
    dir_run_nxt = dir_run_r;
    ival_cnt_nxt = ival_cnt_r;
    per_cnt_nxt = per_full ? per_cnt_r : per_cnt_r + PER_ONE;
    period_nxt = period_r;
    stst_nxt = stst_r;
    if (res_chg) begin
      // Coarser: jump to snapped spot; finer: jump to current target
      pos_nxt = tgt_base;
      rem_nxt = REM_ZERO;
      ival_cnt_nxt = PER_ZERO;
    end
    if (per_full) begin
      stst_nxt = 1'b1;
      period_nxt = PER_MAX;
    end
    if (step_rise) begin
      tgt_nxt = tgt_step;
      // Unissued microsteps of the old step are dropped
      pos_nxt = tgt_base;
      dir_run_nxt = dir_s2_r;
      ival_cnt_nxt = PER_ZERO;
      per_cnt_nxt = PER_ONE;
      stst_nxt = 1'b0;
      period_nxt = stst_r ? PER_MAX : per_cnt_r;
      if (res_new == RES_FINEST) begin
        pos_nxt = tgt_step;
        rem_nxt = REM_ZERO;
      end else begin
        rem_nxt = 9'(width_new);
      end
    end else if (ival_tick && !res_chg) begin
      pos_nxt = dir_run_r ? pos_r - 10'h001 : pos_r + 10'h001;
      rem_nxt = rem_r - 9'h001;
      ival_cnt_nxt = PER_ZERO;
    end else if (rem_r != REM_ZERO && !res_chg) begin
      ival_cnt_nxt = ival_cnt_r + PER_ONE;
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      res_r <= RES_FINEST;
      tgt_r <= POS_RST;
      pos_r <= POS_RST;
      rem_r <= REM_ZERO;
      dir_run_r <= 1'b0;
      ival_cnt_r <= PER_ZERO;
      per_cnt_r <= PER_ZERO;
      period_r <= PER_MAX;
      stst_r <= 1'b1;
    end else begin
      res_r <= res_new;
      tgt_r <= tgt_nxt;
      pos_r <= pos_nxt;
      rem_r <= rem_nxt;
      dir_run_r <= dir_run_nxt;
      ival_cnt_r <= ival_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      period_r <= period_nxt;
      stst_r <= stst_nxt;
    end
  end

  // Reduction only when the pin selects it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      standby_r <= 1'b0;
    end else begin
      standby_r <= stst_nxt & pdn_s2_r;
    end
  end

  // Cosine is the same table a quarter period ahead
  ssq_sine_rom u_rom (
    .mclk(mclk),
    .idx_a(pos_r),
    .idx_b(pos_r + QUARTER_OFS),
    .cur_a(rom_a),
    .cur_b(rom_b)
  );

  // Output flops; currents lag the counter by two cycles
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      coil_a_cur <= '0;
      coil_b_cur <= '0;
    end else begin
      coil_a_cur <= rom_a;
      coil_b_cur <= rom_b;
    end
  end

  assign microstep_position_count = pos_r;
  assign standstill = stst_r;
  assign standby_reduce = standby_r;

  // Checks on the sequencer
  sync_depth_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise |-> $past(step_in, 2) && !$past(step_in, 3))
    else $error("step edge not two flops behind pin");

  tgt_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (tgt_r != $past(tgt_r)) |-> $past(step_rise) || $past(res_up))
    else $error("target moved without a rising step");

  step_up_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise && !dir_s2_r && !res_chg |=>
      tgt_r == $past(tgt_r) + $past(width_new))
    else $error("forward step did not add width");

  step_dn_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise && dir_s2_r && !res_chg |=>
      tgt_r == $past(tgt_r) - $past(width_new))
    else $error("reverse step did not subtract width");

  snap_valid_a: assert property (@(posedge mclk) disable iff (sys_rst)
    res_up && !step_rise |=>
      ((tgt_r & ~mask_new) == half_new) && pos_r == tgt_r)
    else $error("coarser resolution not snapped");

  full_valid_a: assert property (@(posedge mclk) disable iff (sys_rst)
    res_r == RES_FULL && $past(res_r) == RES_FULL |-> tgt_r[7:0] == FULL_LOW)
    else $error("full step position invalid");

  half_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
    res_up && res_new == RES_HALF && !step_rise |=>
      (tgt_r & 10'h07f) == HALF_FIRST)
    else $error("half step position invalid");

  quarter_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
    res_up && res_new == RES_QUARTER && !step_rise |=>
      (tgt_r & 10'h03f) == QUARTER_FIRST)
    else $error("quarter step position invalid");

  drop_rest_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise && !res_chg && res_r != RES_FINEST |=>
      pos_r == $past(tgt_r) && rem_r == 9'($past(width_new)))
    else $error("new step did not restart from target");

  stst_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    per_full && !step_rise |=> stst_r && period_r == PER_MAX)
    else $error("standstill not declared at period limit");

  stst_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise |=> !stst_r)
    else $error("standstill not cleared by step");

  standby_a: assert property (@(posedge mclk) disable iff (sys_rst)
    standby_r |-> stst_r && $past(pdn_s2_r))
    else $error("reduction without standstill or pin");

  micro_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (pos_r != $past(pos_r)) && !$past(step_rise) && !$past(res_chg) |->
      (pos_r - $past(pos_r) == 10'h001) || ($past(pos_r) - pos_r == 10'h001))
    else $error("interpolated move not one entry");

  reset_state_a: assert property (@(posedge mclk)
    sys_rst |=> stst_r && pos_r == POS_RST && period_r == PER_MAX)
    else $error("reset state wrong");

  fine_direct_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise && res_new == RES_FINEST |=> pos_r == tgt_r && rem_r == REM_ZERO)
    else $error("finest step did not move directly");

  dir_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
    step_rise |=> dir_run_r == $past(dir_s2_r))
    else $error("run direction not taken at step");

  rem_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rem_r <= REM_MAX)
    else $error("microstep backlog above one full step");

  ival_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rem_r != REM_ZERO |-> ival_cnt_r <= ival_last)
    else $error("microstep interval overran");

  per_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
    per_cnt_r <= PER_MAX && period_r <= PER_MAX)
    else $error("period above limit");

  standby_on_a: assert property (@(posedge mclk) disable iff (sys_rst)
    stst_r && $past(pdn_s2_r) |-> standby_r)
    else $error("reduction missing in standstill");

  res_take_a: assert property (@(posedge mclk) disable iff (sys_rst)
    res_hold_r != $past(res_hold_r) |-> $past(res_s2_r == res_s3_r))
    else $error("resolution taken from unsettled code");

  coil_pos_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(pos_r[POS_W-1], 2) |-> coil_a_cur >= 9'sh000)
    else $error("coil a negative in first half");

  coil_neg_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(pos_r[POS_W-1], 2) |-> coil_a_cur <= 9'sh000)
    else $error("coil a positive in second half");

  width_pow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (width_new & (width_new - 10'h001)) == 10'h000 && width_new <= 10'h100)
    else $error("step width not a power of two");
endmodule : ssq_sequencer
`default_nettype wire

/* tb/ssq_step_source.sv */
// Step and direction source standing in for the motion controller
`timescale 1ns/1ns
`default_nettype none
module ssq_step_source (
  output logic step_in,
  output logic dir_in,
  input wire logic mclk
);
  initial begin
    step_in = 1'b0;
    dir_in = 1'b0;
  end
  // One step; direction settles three clocks ahead of the rising edge
  task automatic pulse(input logic d, input int hi, input int lo);
    @(negedge mclk) dir_in = d;
    repeat (3) @(negedge mclk);
    step_in = 1'b1;
    // At least one clock high and low keeps the rate at half clock
    repeat ((hi < 1) ? 1 : hi) @(negedge mclk);
    step_in = 1'b0;
    repeat ((lo < 1) ? 1 : lo) @(negedge mclk);
  endtask : pulse
endmodule : ssq_step_source
`default_nettype wire

/* tb/step_dir_microstep_sequencer_bench.sv */
// Self-checking bench for the step/direction microstep sequencer
`timescale 1ns/1ns
`default_nettype none
module step_dir_microstep_sequencer_bench;
  import ssq_pkg::*;
  localparam int STST = 64;
  logic mclk, sys_rst, pds, step_in, dir_in, stst, sbr, mon_on;
  logic [RES_W-1:0] res_sel;
  logic [RES_W-1:0] codes [3] = '{RES_QUARTER, RES_HALF, RES_FULL};
  logic [POS_W-1:0] pos, last, mdl, w;
  logic [POS_W-1:0] exp_q [$];
  logic signed [CUR_W-1:0] ca, cb;
  logic [31:0] rng;
  int err_total, total_checks, cyc;

  ssq_step_source i_src (.step_in(step_in), .dir_in(dir_in), .mclk(mclk));
  ssq_sequencer #(.STST_CYCLES(STST)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .step_in(step_in), .dir_in(dir_in),
    .res_sel(res_sel), .power_down_select_pin(pds),
    .microstep_position_count(pos), .coil_a_cur(ca), .coil_b_cur(cb),
    .standstill(stst), .standby_reduce(sbr));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Note the next one-entry move, then send the pulse with random widths
  task automatic step_one(input logic d);
    mdl = d ? mdl - 10'h001 : mdl + 10'h001;
    exp_q.push_back(mdl);
    rng = xs(rng);
    i_src.pulse(d, 1 + int'(rng[1:0]), 1 + int'(rng[3:2]));
  endtask : step_one

  // Bounded wait until every noted move has shown up
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    check("pending moves", exp_q.size(), 0);
    repeat (4) @(negedge mclk);
  endtask : drain

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Any counter move must be the oldest noted one; a stray move is an error
  always @(negedge mclk) begin
    if (mon_on && pos !== last) begin
      if (exp_q.size() == 0) begin
        check("unexpected count move", pos, last);
      end else begin
        check("count", pos, exp_q.pop_front());
      end
    end
    last = pos;
  end

  // Hang guard; the whole run needs well under two thousand clocks
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("ERROR run length expected end seen hang");
      complete_run();
    end
  end

  initial begin
    sys_rst = 1'b1;
    pds = 1'b1;
    res_sel = RES_FINEST;
    mon_on = 1'b0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    rng = 32'hd3d5;
    mdl = POS_RST;
    last = POS_RST;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    check("count after reset", pos, POS_RST);
    check("standstill after reset", stst, 1'b1);
    mon_on = 1'b1;
    repeat (4) @(negedge mclk);
    $display("test reset done");
    // Fine steps: wrap below zero and back, then a random walk
    step_one(1'b1);
    drain;
    check("standstill cleared", stst, 1'b0);
    check("reduce off while moving", sbr, 1'b0);
    step_one(1'b0);
    for (int i = 0; i < 40; i++) begin
      rng = xs(rng);
      step_one(rng[4]);
    end
    drain;
    $display("test fine steps done");
    // Standstill only after the shortened period limit runs out
    step_one(1'b0);
    repeat (30) @(negedge mclk);
    check("standstill early", stst, 1'b0);
    repeat (60) @(negedge mclk);
    check("standstill late", stst, 1'b1);
    check("reduce with pin high", sbr, 1'b1);
    pds = 1'b0;
    repeat (6) @(negedge mclk);
    check("reduce with pin low", sbr, 1'b0);
    pds = 1'b1;
    exp_q.delete();
    $display("test standstill done");
    // Coarser resolutions snap to the middle of their step slot
    foreach (codes[k]) begin
      w = 10'h001 << codes[k];
      if (((mdl & ~(w - 10'h001)) + (w >> 1)) != mdl) begin
        mdl = (mdl & ~(w - 10'h001)) + (w >> 1);
        exp_q.push_back(mdl);
      end
      res_sel = codes[k];
      repeat (4) @(negedge mclk);
      drain;
    end
    check("full slot", pos[7:0], FULL_LOW);
    $display("test resolution done");
    // Full steps each way walk 256 single-entry microsteps
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 256; k++) begin
        mdl = (d == 1) ? mdl - 10'h001 : mdl + 10'h001;
        exp_q.push_back(mdl);
      end
      i_src.pulse(d[0], 2, 2);
      drain;
      check("coil balance", (ca < 0) ? -ca : ca, (cb < 0) ? -cb : cb);
      check("coil a sign", ca > 0, pos < 10'h200);
      check("coil b sign", cb > 0, pos < 10'h100 || pos >= 10'h300);
    end
    $display("test full walk done");
    complete_run();
  end
endmodule : step_dir_microstep_sequencer_bench
`default_nettype wire
